// ===== hdl/psir_pkg.sv
// Constants, field positions and carrier types of the PHY status and
// interrupt register set.
// Assumes one 100 MHz clock and a management port that reads one register
// per strobe.
package psir_pkg;
  localparam logic [4:0] ADDR_EXT_CTRL = 5'h11;
  localparam logic [4:0] ADDR_INT_STATUS = 5'h15;
  localparam logic [4:0] ADDR_INT_MASK = 5'h16;
  localparam logic [4:0] ADDR_COMM = 5'h17;
  localparam logic [4:0] ADDR_GENERAL = 5'h18;
  localparam logic [4:0] ADDR_EXTERNAL = 5'h19;
  localparam logic [4:0] ADDR_RX_FAIL = 5'h1a;
  localparam logic [15:0] INT_MASK_RESET = 16'h8000;
  localparam int IS_POWER_ON_FLAG = 15;
  localparam int IS_WAKE = 14;
  localparam int IS_WUR = 13;
  localparam int IS_LPS = 12;
  localparam int IS_INIT = 11;
  localparam int IS_LINK_FAIL = 10;
  localparam int IS_LINK_UP = 9;
  localparam int IS_SYM = 8;
  localparam int IS_TRAIN = 7;
  localparam int IS_SNR = 6;
  localparam int IS_CTRL = 5;
  localparam int IS_CLAMP = 4;
  localparam int IS_UV = 3;
  localparam int IS_UV_REC = 2;
  localparam int IS_TEMP = 1;
  localparam int IS_ABORT = 0;
  localparam logic [15:0] LINK_CLEAR_MASK = 16'h0740;
  localparam int MODE_LSB = 11;
  localparam logic [3:0] MODE_NO_CHANGE = 4'h0;
  localparam logic [3:0] MODE_NORMAL = 4'h3;
  localparam logic [3:0] MODE_STANDBY = 4'hc;
  localparam logic [3:0] MODE_SLEEP_REQ = 4'hb;
  localparam logic [2:0] SNR_NO_LIMIT = 3'h0;
  localparam logic [4:0] LINK_CNT_MAX = 5'h1f;
  localparam logic [7:0] RX_CNT_MAX = 8'hff;

  typedef struct packed {
    logic power_on_flag;
    logic wake_event_flag;
    logic wake_request_rx_flag;
    logic low_power_symbol_rx_flag;
    logic init_failure_flag;
    logic symbol_error_flag;
    logic training_failure_flag;
    logic tx_enable_clamp_flag;
    logic undervoltage_recovered_flag;
    logic overtemp_event;
    logic sleep_abort_event;
    logic enter_sleep_request;
    logic enter_standby_uv;
    logic uv_in_standby;
  } psir_events_type;

  typedef struct packed {
    logic link_control_en;
    logic link_good;
    logic [1:0] tx_mode;
    logic local_rx_ok;
    logic remote_rx_ok;
    logic descrambler_lock;
    logic stream_start_delim_error;
    logic stream_end_delim_error;
    logic [2:0] signal_quality_class;
    logic [2:0] snr_warn_limit;
    logic receive_error;
    logic transmit_error;
    logic [2:0] code_a;
  } psir_link_type;

  typedef struct packed {
    logic pll_locked;
    logic local_wake_flag;
    logic remote_wake_flag;
    logic in_sleep_request;
    logic rx_data_valid;
    logic transmit_enable_input;
    logic enable_pin;
    logic uv_analog_3v3;
    logic uv_digital_1v8;
    logic uv_analog_1v8;
    logic uv_io_supply;
    logic temp_high;
    logic temp_warn;
    logic short_detect;
    logic open_detect;
    logic interleave_b_first;
  } psir_monitor_type;
endpackage

// ===== hdl/psir_regs.sv
// Status and interrupt register set of a single-pair Ethernet PHY.
// Assumes all event and status inputs are synchronous to clock and that
// the management port gives one-cycle read and write strobes.
module psir_regs
  import psir_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic [4:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire psir_events_type evt,
  input wire psir_link_type link,
  input wire psir_monitor_type mon,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid
);

  // ****************************************************************
  // Event detection
  // ****************************************************************
  logic link_good_reg;
  logic local_ok_reg;
  logic remote_ok_reg;
  logic enable_pin_reg;
  logic [15:0] int_status_reg;
  logic [15:0] int_status_next;
  logic [15:0] int_mask_reg;
  logic [15:0] int_set;
  logic link_clear;
  logic mode_bad;
  logic snr_low;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      link_good_reg <= 1'b0;
      local_ok_reg <= 1'b0;
      remote_ok_reg <= 1'b0;
      enable_pin_reg <= 1'b1;
    end
    else
    begin
      link_good_reg <= link.link_good;
      local_ok_reg <= link.local_rx_ok;
      remote_ok_reg <= link.remote_rx_ok;
      enable_pin_reg <= mon.enable_pin;
    end
  end

  assign mode_bad = reg_wr && reg_addr == ADDR_EXT_CTRL &&
    !(reg_wdata[MODE_LSB+:4] inside {MODE_NO_CHANGE, MODE_NORMAL,
      MODE_STANDBY, MODE_SLEEP_REQ});
  assign snr_low = link.snr_warn_limit != SNR_NO_LIMIT &&
    link.signal_quality_class < link.snr_warn_limit && link.link_good;
  assign link_clear = evt.enter_sleep_request || evt.enter_standby_uv ||
    evt.uv_in_standby;

  always_comb
  begin
    int_set = '0;
    int_set[IS_POWER_ON_FLAG] = evt.power_on_flag;
    int_set[IS_WAKE] = evt.wake_event_flag;
    int_set[IS_WUR] = evt.wake_request_rx_flag;
    int_set[IS_LPS] = evt.low_power_symbol_rx_flag;
    int_set[IS_INIT] = evt.init_failure_flag;
    int_set[IS_LINK_FAIL] = link_good_reg && !link.link_good;
    int_set[IS_LINK_UP] = !link_good_reg && link.link_good;
    int_set[IS_SYM] = evt.symbol_error_flag;
    int_set[IS_TRAIN] = evt.training_failure_flag;
    int_set[IS_CTRL] = mode_bad;
    int_set[IS_CLAMP] = evt.tx_enable_clamp_flag;
    int_set[IS_SNR] = snr_low;
    int_set[IS_UV] = mon.uv_analog_3v3 || mon.uv_digital_1v8 ||
      mon.uv_analog_1v8 || mon.uv_io_supply;
    int_set[IS_UV_REC] = evt.undervoltage_recovered_flag;
    int_set[IS_TEMP] = evt.overtemp_event;
    int_set[IS_ABORT] = evt.sleep_abort_event;
  end

  function automatic logic is_read(input logic rd, input logic [4:0] a,
    input logic [4:0] target);
    is_read = rd && a == target;
  endfunction

  // ****************************************************************
  // Interrupt status and mask
  // ****************************************************************
  always_comb
  begin
    int_status_next = int_status_reg;
    if (is_read(reg_rd, reg_addr, ADDR_INT_STATUS))
      int_status_next = '0;
    if (link_clear)
      int_status_next = int_status_next & ~LINK_CLEAR_MASK;
    int_status_next = int_status_next | int_set;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      int_status_reg <= '0;
    else
      int_status_reg <= int_status_next;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      int_mask_reg <= INT_MASK_RESET;
    else if (reg_wr && reg_addr == ADDR_INT_MASK)
      int_mask_reg <= reg_wdata;
  end

  // ****************************************************************
  // Communication status latches
  // ****************************************************************
  logic loc_fail_seen_reg;
  logic rem_fail_seen_reg;
  logic stream_start_delim_error_reg;
  logic stream_end_delim_error_reg;
  logic rx_err_reg;
  logic tx_err_reg;
  logic comm_rd;

  assign comm_rd = is_read(reg_rd, reg_addr, ADDR_COMM);

  always_ff @(posedge clock)
  begin
    if (srst || !link.link_control_en)
    begin
      loc_fail_seen_reg <= 1'b0;
      rem_fail_seen_reg <= 1'b0;
      stream_start_delim_error_reg <= 1'b0;
      stream_end_delim_error_reg <= 1'b0;
      rx_err_reg <= 1'b0;
      tx_err_reg <= 1'b0;
    end
    else
    begin
      loc_fail_seen_reg <= (loc_fail_seen_reg && !comm_rd) ||
        !link.local_rx_ok;
      rem_fail_seen_reg <= (rem_fail_seen_reg && !comm_rd) ||
        !link.remote_rx_ok;
      stream_start_delim_error_reg <= (stream_start_delim_error_reg && !comm_rd) ||
        link.stream_start_delim_error;
      stream_end_delim_error_reg <= (stream_end_delim_error_reg && !comm_rd) ||
        link.stream_end_delim_error;
      rx_err_reg <= (rx_err_reg && !comm_rd) || link.receive_error;
      tx_err_reg <= (tx_err_reg && !comm_rd) || link.transmit_error;
    end
  end

  // ****************************************************************
  // General and external status latches
  // ****************************************************************
  logic pll_lost_reg;
  logic loc_wake_reg;
  logic rem_wake_reg;
  logic act_wake_reg;
  logic en_low_reg;
  logic hw_reset_reg;
  logic [4:0] link_loss_count_reg;
  logic gen_rd;
  logic ext_rd;
  logic [3:0] uv_reg;
  logic temp_high_reg;
  logic temp_warn_reg;
  logic short_reg;
  logic open_reg;

  assign gen_rd = is_read(reg_rd, reg_addr, ADDR_GENERAL);
  assign ext_rd = is_read(reg_rd, reg_addr, ADDR_EXTERNAL);

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pll_lost_reg <= 1'b0;
      loc_wake_reg <= 1'b0;
      rem_wake_reg <= 1'b0;
      act_wake_reg <= 1'b0;
      en_low_reg <= 1'b0;
      hw_reset_reg <= 1'b1;
    end
    else
    begin
      pll_lost_reg <= (pll_lost_reg && !gen_rd) || !mon.pll_locked;
      loc_wake_reg <= (loc_wake_reg && !gen_rd) || mon.local_wake_flag;
      rem_wake_reg <= (rem_wake_reg && !gen_rd) || mon.remote_wake_flag;
      act_wake_reg <= (act_wake_reg && !gen_rd) || (mon.in_sleep_request &&
        (mon.rx_data_valid || mon.transmit_enable_input));
      en_low_reg <= (en_low_reg && !gen_rd) ||
        (enable_pin_reg && !mon.enable_pin);
      hw_reset_reg <= hw_reset_reg && !gen_rd;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      link_loss_count_reg <= '0;
    else if (link_good_reg && !link.link_good)
    begin
      if (gen_rd)
        link_loss_count_reg <= 5'h01;
      else if (link_loss_count_reg != LINK_CNT_MAX)
        link_loss_count_reg <= link_loss_count_reg + 5'h01;
    end
    else if (gen_rd)
      link_loss_count_reg <= '0;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      uv_reg <= '0;
      temp_high_reg <= 1'b0;
      temp_warn_reg <= 1'b0;
      short_reg <= 1'b0;
      open_reg <= 1'b0;
    end
    else
    begin
      uv_reg <= (uv_reg & {4{!ext_rd}}) | {mon.uv_analog_3v3,
        mon.uv_digital_1v8, mon.uv_analog_1v8, mon.uv_io_supply};
      temp_high_reg <= (temp_high_reg && !ext_rd) || mon.temp_high;
      temp_warn_reg <= (temp_warn_reg && !ext_rd) || mon.temp_warn;
      short_reg <= (short_reg && !ext_rd) || mon.short_detect;
      open_reg <= (open_reg && !ext_rd) || mon.open_detect;
    end
  end

  // ****************************************************************
  // Receiver fail counters
  // ****************************************************************
  logic [7:0] loc_cnt_reg;
  logic [7:0] rem_cnt_reg;
  logic cnt_rd;

  assign cnt_rd = is_read(reg_rd, reg_addr, ADDR_RX_FAIL);

  function automatic logic [7:0] cnt_next(input logic [7:0] c,
    input logic rd, input logic inc);
    logic [7:0] base;
    base = rd ? 8'h00 : c;
    cnt_next = (inc && base != RX_CNT_MAX) ? base + 8'h01 : base;
  endfunction

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      loc_cnt_reg <= '0;
      rem_cnt_reg <= '0;
    end
    else
    begin
      loc_cnt_reg <= cnt_next(loc_cnt_reg, cnt_rd,
        local_ok_reg && !link.local_rx_ok);
      rem_cnt_reg <= cnt_next(rem_cnt_reg, cnt_rd,
        remote_ok_reg && !link.remote_rx_ok);
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  logic [15:0] rd_value;
  logic lc;

  assign lc = link.link_control_en;

  always_comb
  begin
    rd_value = '0;
    unique case (reg_addr)
      ADDR_INT_STATUS: rd_value = int_status_reg;
      ADDR_INT_MASK: rd_value = int_mask_reg;
      ADDR_COMM: rd_value = {lc && link.link_good,
        lc ? link.tx_mode : 2'b00,
        lc && link.local_rx_ok && !loc_fail_seen_reg,
        lc && link.remote_rx_ok && !rem_fail_seen_reg,
        lc && link.descrambler_lock, stream_start_delim_error_reg, stream_end_delim_error_reg,
        lc ? link.signal_quality_class : 3'b000, rx_err_reg, tx_err_reg,
        link.code_a};
      ADDR_GENERAL: rd_value = {|(int_status_reg & int_mask_reg),
        mon.pll_locked && !pll_lost_reg, loc_wake_reg, rem_wake_reg,
        act_wake_reg, en_low_reg, hw_reset_reg, 1'b0,
        link_loss_count_reg, 3'b000};
      ADDR_EXTERNAL: rd_value = {1'b0, uv_reg, temp_high_reg,
        temp_warn_reg, short_reg, open_reg, 1'b0, mon.interleave_b_first,
        5'b00000};
      ADDR_RX_FAIL: rd_value = {loc_cnt_reg, rem_cnt_reg};
      default: rd_value = '0;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      reg_rdata <= '0;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        reg_rdata <= rd_value;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  a_link_fail_flag: assert property (
    link_good_reg && !link.link_good |=> int_status_reg[IS_LINK_FAIL])
    else $error("link fail flag not latched");
  a_link_up_flag: assert property (
    !link_good_reg && link.link_good |=> int_status_reg[IS_LINK_UP])
    else $error("link up flag not latched");
  a_ctrl_err_flag: assert property (
    mode_bad |=> int_status_reg[IS_CTRL])
    else $error("control error not latched");
  a_link_clear_bits: assert property (
    link_clear && !int_set[IS_SYM] |=> !int_status_reg[IS_SYM])
    else $error("symbol flag survived clear");
  a_read_keeps_event: assert property (
    is_read(reg_rd, reg_addr, ADDR_INT_STATUS) && evt.power_on_flag
    |=> int_status_reg[IS_POWER_ON_FLAG])
    else $error("event lost in read cycle");
  a_read_clears_status: assert property (
    is_read(reg_rd, reg_addr, ADDR_INT_STATUS) && int_set == '0 &&
    !link_clear |=> int_status_reg == '0)
    else $error("read did not clear status");
  a_pending_summary: assert property (
    reg_rd && reg_addr == ADDR_GENERAL |=>
    reg_rdata[15] == |($past(int_status_reg) & $past(int_mask_reg)))
    else $error("pending summary wrong");
  a_count_saturates: assert property (
    loc_cnt_reg == RX_CNT_MAX && !cnt_rd |=> loc_cnt_reg == RX_CNT_MAX)
    else $error("counter wrapped");
  a_count_clears: assert property (
    cnt_rd && !(local_ok_reg && !link.local_rx_ok) |=> loc_cnt_reg == '0)
    else $error("counter not cleared on read");
  a_comm_default: assert property (
    !link.link_control_en |=> !stream_start_delim_error_reg && !rx_err_reg)
    else $error("comm latch kept without link control");
  a_read_answer: assert property (
    reg_rd |=> reg_rvalid ##1 !reg_rvalid || $past(reg_rd))
    else $error("read answer timing wrong");

  c_link_drop: cover property (link_good_reg ##1 !link_good_reg);
  c_ctrl_error: cover property (mode_bad);
  c_cnt_full: cover property (loc_cnt_reg == RX_CNT_MAX);
  c_pending_read: cover property (gen_rd && |(int_status_reg & int_mask_reg));

endmodule

// ===== sim/psir_host.sv
// Management host model that reads and writes the status registers.
// Assumes the design takes one strobe per cycle and answers a cycle later.
module psir_host
  import psir_pkg::*;
(
  input wire logic clock,
  output logic [4:0] reg_addr,
  output logic reg_rd,
  output logic reg_wr,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    reg_addr = 5'h00;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
  end

  // Released lines carry the inverse so a stale value is never reused.
  task automatic read(input logic [4:0] addr, output logic [15:0] data,
                      output logic ok);
    @(posedge clock);
    #1 reg_addr = addr;
    reg_rd = 1'b1;
    @(posedge clock);
    #1 reg_rd = 1'b0;
    reg_addr = ~addr;
    ok = reg_rvalid;
    data = reg_rdata;
  endtask

  task automatic write(input logic [4:0] addr, input logic [15:0] data);
    @(posedge clock);
    #1 reg_addr = addr;
    reg_wdata = data;
    reg_wr = 1'b1;
    @(posedge clock);
    #1 reg_wr = 1'b0;
    reg_addr = ~addr;
    reg_wdata = ~data;
  endtask
endmodule

// ===== sim/phy_status_interrupt_regs_tb.sv
// Self-checking bench for the PHY status and interrupt register set.
// Assumes the design answers reads one cycle after the strobe.
module phy_status_interrupt_regs_tb
  import psir_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [4:0] reg_addr;
  logic reg_rd;
  logic reg_wr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic reg_rvalid;
  psir_events_type evt;
  psir_link_type link;
  psir_monitor_type mon;
  int fail_count = 0;
  int samples_checked = 0;

  always #5 clock = ~clock;

  psir_regs DUT (.clock(clock), .srst(srst), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .evt(evt),
    .link(link), .mon(mon), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  psir_host host (.clock(clock), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [4:0] addr, input logic [15:0] exp);
    logic [15:0] d;
    logic ok;
    host.read(addr, d, ok);
    chk({15'h0000, ok}, 16'h0001);
    chk(d, exp);
  endtask

  task automatic pulse_evt(input psir_events_type v);
    @(posedge clock);
    #1 evt = v;
    @(posedge clock);
    #1 evt = '0;
  endtask

  // Inverts one monitor input for a single cycle.
  task automatic blip(input int k);
    @(posedge clock);
    #1 mon[k] = ~mon[k];
    @(posedge clock);
    #1 mon[k] = ~mon[k];
  endtask

  task automatic raise_sq();
    psir_events_type v;
    v = '0;
    v.symbol_error_flag = 1'b1;
    pulse_evt(v);
    link.signal_quality_class = 3'h3;
    @(posedge clock);
    #1 link.signal_quality_class = 3'h7;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rd_chk(ADDR_INT_MASK, INT_MASK_RESET);
    rd_chk(ADDR_GENERAL, 16'h4200);
    rd_chk(ADDR_GENERAL, 16'h4000);
    rd_chk(ADDR_RX_FAIL, 16'h0000);
    rd_chk(ADDR_INT_STATUS, 16'h0000);
  endtask

  task automatic t_events();
    int ev[11] = '{13, 12, 11, 10, 9, 8, 7, 6, 5, 4, 3};
    int ib[11] = '{15, 14, 13, 12, 11, 8, 7, 4, 2, 1, 0};
    psir_events_type v;
    for (int i = 0; i < 11; i++)
    begin
      v = '0;
      v[ev[i]] = 1'b1;
      pulse_evt(v);
      rd_chk(ADDR_INT_STATUS, 16'h0001 << ib[i]);
    end
  endtask

  task automatic t_link();
    psir_events_type v;
    @(posedge clock);
    #1 link.snr_warn_limit = 3'h4;
    link.link_good = 1'b1;
    raise_sq();
    rd_chk(ADDR_INT_STATUS, 16'h0340);
    for (int i = 0; i < 3; i++)
    begin
      raise_sq();
      v = '0;
      v[2 - i] = 1'b1;
      pulse_evt(v);
      rd_chk(ADDR_INT_STATUS, 16'h0000);
    end
    link.link_good = 1'b0;
    rd_chk(ADDR_INT_STATUS, 16'h0400);
    rd_chk(ADDR_GENERAL, 16'h4008);
    @(posedge clock);
    #1 link.signal_quality_class = 3'h1;
    @(posedge clock);
    #1 link.signal_quality_class = 3'h7;
    rd_chk(ADDR_INT_STATUS, 16'h0000);
  endtask

  task automatic t_ctrl();
    logic [3:0] good[4] = '{MODE_NO_CHANGE, MODE_NORMAL, MODE_STANDBY,
                            MODE_SLEEP_REQ};
    for (int i = 0; i < 4; i++)
    begin
      host.write(ADDR_EXT_CTRL, {1'b0, good[i], 11'h000});
      rd_chk(ADDR_INT_STATUS, 16'h0000);
    end
    host.write(ADDR_EXT_CTRL, 16'h2000);
    rd_chk(ADDR_GENERAL, 16'h4000);
    rd_chk(ADDR_INT_STATUS, 16'h0020);
    host.write(ADDR_INT_MASK, 16'h0020);
    rd_chk(ADDR_INT_MASK, 16'h0020);
    host.write(ADDR_EXT_CTRL, 16'h2000);
    rd_chk(ADDR_GENERAL, 16'hc000);
    rd_chk(ADDR_INT_STATUS, 16'h0020);
    rd_chk(ADDR_GENERAL, 16'h4000);
    host.write(ADDR_INT_STATUS, 16'hffff);
    rd_chk(ADDR_INT_STATUS, 16'h0000);
    rd_chk(5'h1b, 16'h0000);
  endtask

  task automatic t_comm();
    logic [15:0] e;
    @(posedge clock);
    #1 link.link_control_en = 1'b1;
    link.link_good = 1'b1;
    link.tx_mode = 2'b10;
    link.descrambler_lock = 1'b1;
    link.signal_quality_class = 3'h5;
    link.code_a = 3'h4;
    @(posedge clock);
    #1 link.stream_start_delim_error = 1'b1;
    link.stream_end_delim_error = 1'b1;
    link.receive_error = 1'b1;
    link.transmit_error = 1'b1;
    @(posedge clock);
    #1 link.stream_start_delim_error = 1'b0;
    link.stream_end_delim_error = 1'b0;
    link.receive_error = 1'b0;
    link.transmit_error = 1'b0;
    rd_chk(ADDR_COMM, 16'hdfbc);
    rd_chk(ADDR_COMM, 16'hdca4);
    @(posedge clock);
    #1 link.local_rx_ok = 1'b0;
    @(posedge clock);
    #1 link.local_rx_ok = 1'b1;
    rd_chk(ADDR_COMM, 16'hcca4);
    rd_chk(ADDR_COMM, 16'hdca4);
    rd_chk(ADDR_RX_FAIL, 16'h0100);
    for (int i = 0; i < 8; i++)
    begin
      link.tx_mode = 2'(i);
      link.signal_quality_class = 3'(i);
      e = 16'h9c04 | (16'(i & 3) << 13) | (16'(i) << 5);
      rd_chk(ADDR_COMM, e);
    end
    link.link_control_en = 1'b0;
    rd_chk(ADDR_COMM, 16'h0004);
    rd_chk(ADDR_INT_STATUS, 16'h0240);
  endtask

  task automatic t_count();
    link.snr_warn_limit = SNR_NO_LIMIT;
    link.signal_quality_class = 3'h0;
    for (int i = 0; i < 260; i++)
    begin
      @(posedge clock);
      #1 link.remote_rx_ok = 1'b0;
      link.local_rx_ok = 1'b0;
      @(posedge clock);
      #1 link.remote_rx_ok = 1'b1;
      link.local_rx_ok = 1'b1;
    end
    rd_chk(ADDR_RX_FAIL, 16'hffff);
    rd_chk(ADDR_RX_FAIL, 16'h0000);
  endtask

  task automatic t_ext();
    rd_chk(ADDR_EXTERNAL, 16'h0000);
    @(posedge clock);
    #1 mon.interleave_b_first = 1'b1;
    for (int k = 1; k < 9; k++)
    begin
      blip(k);
      rd_chk(ADDR_EXTERNAL, (16'h0001 << (k + 6)) | 16'h0020);
    end
    rd_chk(ADDR_EXTERNAL, 16'h0020);
    rd_chk(ADDR_INT_STATUS, 16'h0008);
  endtask

  task automatic t_gen();
    int ks[6] = '{15, 14, 13, 11, 10, 9};
    logic [15:0] ex[6] = '{16'h0000, 16'h6000, 16'h5000, 16'h4800,
                           16'h4800, 16'h4400};
    @(posedge clock);
    #1 mon.in_sleep_request = 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      blip(ks[i]);
      rd_chk(ADDR_GENERAL, ex[i]);
    end
    mon.in_sleep_request = 1'b0;
    blip(11);
    rd_chk(ADDR_GENERAL, 16'h4000);
  endtask

  task automatic t_collide();
    logic [15:0] d;
    logic ok;
    psir_events_type v;
    v = '0;
    v.symbol_error_flag = 1'b1;
    fork
      host.read(ADDR_INT_STATUS, d, ok);
      pulse_evt(v);
    join
    chk(d, 16'h0000);
    rd_chk(ADDR_INT_STATUS, 16'h0100);
  endtask

  task automatic t_rst2();
    @(posedge clock);
    #1 srst = 1'b1;
    repeat (2) @(posedge clock);
    #1 srst = 1'b0;
    rd_chk(ADDR_INT_MASK, INT_MASK_RESET);
    rd_chk(ADDR_GENERAL, 16'h4200);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    evt = '0;
    link = '0;
    link.local_rx_ok = 1'b1;
    link.remote_rx_ok = 1'b1;
    link.signal_quality_class = 3'h7;
    mon = '0;
    mon.pll_locked = 1'b1;
    mon.enable_pin = 1'b1;
    repeat (5) @(posedge clock);
    #1 srst = 1'b0;
    t_reset();
    t_events();
    t_link();
    t_ctrl();
    t_comm();
    t_count();
    t_ext();
    t_gen();
    t_collide();
    t_rst2();
    report_and_stop();
  end

  initial
  begin
    #100000;
    fail_count++;
    report_and_stop();
  end
endmodule
